// [abx_alu.sv]
// Accumulator arithmetic and logic unit
`timescale 1ns/1ps
module abx_alu
#(
    parameter int W = 16
)
(
    // Operation and operands
    input  wire abx_pkg::abx_alu_op_type op,
    input  wire logic [W-1:0]            a,
    input  wire logic [W-1:0]            b,
    input  wire logic                    cin,
    // Result and arithmetic flags
    output logic [W-1:0]                 result,
    output logic                         carry,
    output logic                         wrap
);
    import abx_pkg::*;
    logic [W:0] sum;
    assign sum = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    always_comb
    begin
        carry = 1'b0;
        wrap  = 1'b0;
        case (op)
            ALU_ADD:
            begin
                result = sum[W-1:0];
                carry  = sum[W];
                wrap   = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
            end
            ALU_AND: result = a & b;
            ALU_CPL: result = ~a;
            default: result = a;
        endcase
    end
endmodule : abx_alu

// [abx_defines.svh]
// Encodings, field positions, reset values and register codes for the executor
`ifndef ABX_DEFINES_SVH
`define ABX_DEFINES_SVH
`define ABX_OP_ADD      7'h4a
`define ABX_OP_ADD_WITH_CARRY     7'h6a
`define ABX_OP_AND      7'h1a
`define ABX_OP_CALL     7'h3d
`define ABX_OP_CMP      7'h78
`define ABX_LOOP_DECREMENT_BRANCH_HI     2'b10
`define ABX_LOOP_DECREMENT_BRANCH_LO     4'hd
`define ABX_BITAND_HI   8'h9a
`define ABX_ACCFAM_LO   4'ha
`define ABX_WORD_CPL    16'h8a1a
`define ABX_WORD_CPLC   16'hda2a
`define ABX_BITSET_LO   4'h7
`define ABX_ACCN_LO     4'h9
`define ABX_SRC_ACC     8'h0a
`define ABX_SRC_AIDX    8'h1a
`define ABX_SRC_POP     8'h0d
`define ABX_SRC_POPI    8'h8d
`define ABX_DST_AP      7'h08
`define ABX_DST_APC     7'h18
`define ABX_DST_PSF     7'h48
`define ABX_DST_PUSH    7'h0d
`define ABX_DST_SP      7'h1d
`define ABX_MOD_SYS     4'h8
`define ABX_MOD_LAST    4'h5
`define ABX_PSF_C       3'h0
`define ABX_PSF_E       3'h1
`define ABX_POINTER_RESET_BIT     3'h7
`define ABX_MODE_INC    2'b01
`define ABX_MODE_DEC    2'b10
`define ABX_APC_RST     4'h0
`define ABX_AP_RST      4'h0
`define ABX_IP_RST      16'h0000
`define ABX_LC_RST      16'h0000
`endif

// [abx_exec_chk_properties.sv]
// Checker for the execution block ports
`timescale 1ns/1ps
module abx_exec_chk
import abx_pkg::*;
#(
    parameter int ACC_WIDTH = 16,
    parameter int SP_WIDTH  = 4
)
(
    // Clock, reset and inputs
    input wire logic                   sys_clk,
    input wire logic                   reset,
    input wire abx_pkg::abx_instr_type instr,
    input wire abx_pkg::abx_load_type  preload,
    // State outputs
    input wire logic [ACC_WIDTH-1:0]   acc_value,
    input wire abx_pkg::abx_flags_type flags,
    input wire logic [15:0]            instruction_pointer,
    input wire logic [SP_WIDTH-1:0]    stack_pointer,
    input wire logic [15:0]            stack_top,
    input wire logic [1:0][15:0]       loop_counter,
    input wire logic                   illegal_instr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_refuse_acc:
        assert property (illegal_instr && !$past(preload.valid) |-> $stable(acc_value))
            else $error("acc changed on refused word");
    a_refuse_ip:
        assert property (illegal_instr |-> instruction_pointer == $past(instruction_pointer) + 16'h0001)
            else $error("ip not stepped on refused word");
    a_refuse_flags:
        assert property (illegal_instr |-> $stable(flags))
            else $error("flags changed on refused word");
    a_call_push:
        assert property ($past(instr.valid && instr.word[14:8] == 7'h3d) && !illegal_instr
            |-> stack_pointer == SP_WIDTH'($past(stack_pointer) + 1'b1)
            && stack_top == $past(instruction_pointer) + 16'h0001 && $stable(flags))
            else $error("call push wrong");
    a_carry_flip:
        assert property ($past(instr.valid && instr.word == 16'hda2a)
            |-> flags.c != $past(flags.c) && flags[3:0] == $past(flags[3:0]))
            else $error("carry complement wrong");
    a_cmp_only_e:
        assert property ($past(instr.valid && instr.word[14:8] == 7'h78) && !illegal_instr
            |-> {flags.c, flags.s, flags.z, flags.ov} == $past({flags.c, flags.s, flags.z, flags.ov}))
            else $error("compare touched other flags");
    a_loop_decrement_branch_count:
        assert property ($past(instr.valid && instr.word[14:13] == 2'b10 && instr.word[11:8] == 4'hd)
            && !illegal_instr |-> loop_counter[$past(instr.word[12])]
            == $past(loop_counter[instr.word[12]]) - 16'h0001 && $stable(flags))
            else $error("loop counter not decremented");
    a_loop_decrement_branch_fall:
        assert property ($past(instr.valid && instr.word[14:13] == 2'b10 && instr.word[11:8] == 4'hd)
            && !illegal_instr && loop_counter[$past(instr.word[12])] == 16'h0000
            |-> instruction_pointer == $past(instruction_pointer) + 16'h0001)
            else $error("loop fall through wrong");
    a_and_keeps:
        assert property ($past(instr.valid && instr.word[14:8] == 7'h1a
            && !(instr.word[15] && instr.word[3:0] == 4'ha)) && !illegal_instr
            |-> {flags.c, flags.e, flags.ov} == $past({flags.c, flags.e, flags.ov}))
            else $error("and touched other flags");
endmodule : abx_exec_chk
bind abx_exec_core abx_exec_chk #(.ACC_WIDTH(ACC_WIDTH), .SP_WIDTH(SP_WIDTH)) abx_exec_chk_i
    (.sys_clk, .reset, .instr, .preload, .acc_value, .flags, .instruction_pointer,
     .stack_pointer, .stack_top, .loop_counter, .illegal_instr);

// [abx_exec_core.sv]
// Single-cycle executor for arithmetic, compare, call and loop-branch words
`timescale 1ns/1ps
`include "abx_defines.svh"
module abx_exec_core
#(
    parameter int         ACC_WIDTH = 16,
    parameter int         SP_WIDTH  = 4,
    parameter logic [5:0] MOD_IMPL  = 6'h3f
)
(
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset,
    // Instruction with external source
    input  wire abx_pkg::abx_instr_type instr,
    // Prefix and preload
    input  wire abx_pkg::abx_pfx_type   pfx,
    input  wire abx_pkg::abx_load_type  preload,
    // Architectural state
    output logic [ACC_WIDTH-1:0]        acc_value,
    output abx_pkg::abx_flags_type      flags,
    output logic [15:0]                 instruction_pointer,
    output logic [SP_WIDTH-1:0]         stack_pointer,
    output logic [15:0]                 stack_top,
    output logic [3:0]                  accumulator_pointer,
    output logic [7:0]                  pointer_control_register,
    output logic [1:0][15:0]            loop_counter,
    // Outside bit writes and fault
    output abx_pkg::abx_bitwr_type      bit_write,
    output logic                        illegal_instr
);
    import abx_pkg::*;

    localparam int W = ACC_WIDTH;

    logic [W-1:0]        acc_bank [0:15];
    logic [15:0]         stack_mem [0:(1<<SP_WIDTH)-1];
    logic [3:0]          apc_bits;
    logic [7:0]          pfx_byte;
    logic                pfx_live;
    abx_class_type       cls;
    logic                exec;
    logic                fault;
    logic                stk_fault;
    logic [W-1:0]        active;
    logic [15:0]         active16;
    logic [15:0]         src_raw;
    logic                src_narrow;
    logic                src_is_acc;
    logic [15:0]         src_word;
    logic [W-1:0]        operand;
    logic [15:0]         target;
    abx_alu_op_type      alu_op;
    logic [W-1:0]        alu_result;
    logic                alu_carry;
    logic                alu_wrap;
    logic [3:0]          step_ap;
    logic                step_active;
    logic                acc_we;
    logic                sz_from_ap;
    logic [3:0]          next_ap;
    logic [3:0]          next_apc;
    abx_flags_type       next_flags;
    logic [15:0]         next_ip;
    logic [SP_WIDTH-1:0] next_sp;
    logic                push_en;
    logic                lc_we;
    logic [15:0]         next_lc;
    logic                bit_ext;
    logic [W-1:0]        next_active;
    logic [W-1:0]        next_acc_value;
    logic                pre_acc;

    function automatic abx_class_type decode_class(input logic [15:0] w);
        abx_class_type c;
        c = CL_NONE;
        if (w == `ABX_WORD_CPL)
            c = CL_CPL;
        else if (w == `ABX_WORD_CPLC)
            c = CL_CPLC;
        else if (w[15:8] == `ABX_BITAND_HI && w[3:0] == `ABX_ACCFAM_LO)
            c = CL_BITAND;
        else if (w[14:8] == `ABX_OP_ADD)
            c = CL_ADD;
        else if (w[14:8] == `ABX_OP_ADD_WITH_CARRY)
            c = CL_ADD_WITH_CARRY;
        else if (w[14:8] == `ABX_OP_AND)
            c = CL_AND;
        else if (w[14:8] == `ABX_OP_CALL)
            c = CL_CALL;
        else if (w[14:8] == `ABX_OP_CMP)
            c = CL_CMP;
        else if (w[14:13] == `ABX_LOOP_DECREMENT_BRANCH_HI && w[11:8] == `ABX_LOOP_DECREMENT_BRANCH_LO)
            c = CL_LOOP_DECREMENT_BRANCH;
        else if (w[15] && w[3:0] == `ABX_BITSET_LO)
            c = CL_BITSET;
        else if (w[15] && (w[7:0] == `ABX_SRC_ACC || w[7:0] == `ABX_SRC_AIDX))
        begin
            if (w[14:8] == `ABX_DST_AP)
                c = CL_MOVE_AP;
            else if (w[14:8] == `ABX_DST_APC)
                c = CL_MOVE_APC;
        end
        return c;
    endfunction : decode_class

    assign cls      = decode_class(instr.word);
    assign exec     = instr.valid;
    assign active   = acc_bank[accumulator_pointer];
    assign active16 = 16'(active);

    assign stk_fault = instr.word[15]
        && (instr.word[7:0] == `ABX_SRC_POP || instr.word[7:0] == `ABX_SRC_POPI)
        && (instr.word[14:8] == `ABX_DST_PUSH || instr.word[14:8] == `ABX_DST_SP);

    // Source operand resolution
    always_comb
    begin
        src_narrow = 1'b1;
        src_is_acc = 1'b0;
        src_raw    = {8'h00, instr.word[7:0]};
        if (instr.word[15])
        begin
            if (instr.word[3:0] == `ABX_ACCN_LO)
            begin
                src_raw    = 16'(acc_bank[instr.word[7:4]]);
                src_narrow = (W == 8);
            end
            else if (instr.word[7:0] == `ABX_SRC_ACC || instr.word[7:0] == `ABX_SRC_AIDX)
            begin
                src_raw    = active16;
                src_narrow = (W == 8);
                src_is_acc = 1'b1;
            end
            else
            begin
                src_raw    = instr.ext_data;
                src_narrow = !instr.ext_wide;
            end
        end
        src_word = src_narrow ? {(pfx_live ? pfx_byte : 8'h00), src_raw[7:0]} : src_raw;
    end

    assign operand = W'(src_word);

    assign target = (!instr.word[15] && !pfx_live)
        ? instruction_pointer + {{8{instr.word[7]}}, instr.word[7:0]}
        : src_word;

    abx_alu #(
        .W (W)
    ) u_alu (
        .op     (alu_op),
        .a      (active),
        .b      (operand),
        .cin    ((cls == CL_ADD_WITH_CARRY) && flags.c),
        .result (alu_result),
        .carry  (alu_carry),
        .wrap   (alu_wrap)
    );

    abx_ptr_step u_step (
        .ap      (accumulator_pointer),
        .ctrl    (apc_bits),
        .step_ap (step_ap),
        .active  (step_active)
    );

    // Execution of one word
    always_comb
    begin
        fault      = 1'b0;
        acc_we     = 1'b0;
        sz_from_ap = 1'b0;
        alu_op     = ALU_ADD;
        next_ap    = accumulator_pointer;
        next_apc   = apc_bits;
        next_flags = flags;
        next_ip    = instruction_pointer + 16'h0001;
        next_sp    = stack_pointer;
        push_en    = 1'b0;
        lc_we      = 1'b0;
        next_lc    = loop_counter[instr.word[12]] - 16'h0001;
        bit_ext    = 1'b0;
        case (cls)
            CL_ADD, CL_ADD_WITH_CARRY, CL_AND:
            begin
                alu_op = (cls == CL_AND) ? ALU_AND : ALU_ADD;
                fault  = src_is_acc;
                acc_we = 1'b1;
                next_ap = step_ap;
                next_flags.s = alu_result[W-1];
                next_flags.z = (alu_result == '0);
                if (cls != CL_AND)
                begin
                    next_flags.c  = alu_carry;
                    next_flags.ov = alu_wrap;
                end
            end
            CL_BITAND:
            begin
                fault = (W == 8) && instr.word[7];
                next_flags.c = flags.c & active16[instr.word[7:4]];
            end
            CL_CPL:
            begin
                alu_op       = ALU_CPL;
                acc_we       = 1'b1;
                next_ap      = step_ap;
                next_flags.s = alu_result[W-1];
                next_flags.z = (alu_result == '0);
            end
            CL_CPLC:
                next_flags.c = !flags.c;
            CL_CALL:
            begin
                next_sp = stack_pointer + SP_WIDTH'(1);
                push_en = 1'b1;
                next_ip = target;
            end
            CL_CMP:
                next_flags.e = (active == operand);
            CL_LOOP_DECREMENT_BRANCH:
            begin
                lc_we = 1'b1;
                if (next_lc != 16'h0000)
                    next_ip = target;
            end
            CL_BITSET:
            begin
                fault = !(instr.word[11:8] == `ABX_MOD_SYS
                    || (instr.word[11:8] <= `ABX_MOD_LAST && MOD_IMPL[instr.word[10:8]]));
                if (instr.word[14:8] == `ABX_DST_PSF)
                begin
                    if (instr.word[6:4] == `ABX_PSF_C)
                        next_flags.c = instr.word[7];
                    else if (instr.word[6:4] == `ABX_PSF_E)
                        next_flags.e = instr.word[7];
                end
                else if (instr.word[14:8] == `ABX_DST_AP)
                begin
                    sz_from_ap = 1'b1;
                    if (!instr.word[6])
                        next_ap[instr.word[5:4]] = instr.word[7];
                end
                else if (instr.word[14:8] == `ABX_DST_APC)
                begin
                    sz_from_ap = 1'b1;
                    if (instr.word[6:4] == `ABX_POINTER_RESET_BIT && instr.word[7])
                        next_ap = 4'h0;
                    else if (!instr.word[6])
                        next_apc[instr.word[5:4]] = instr.word[7];
                end
                else
                    bit_ext = 1'b1;
            end
            CL_MOVE_AP:
            begin
                sz_from_ap = 1'b1;
                if (instr.word[7:0] == `ABX_SRC_ACC && step_active)
                    next_ap = step_ap;
                else
                    next_ap = active[3:0];
            end
            CL_MOVE_APC:
            begin
                sz_from_ap = 1'b1;
                next_apc   = active[3:0];
                if (active[7])
                    next_ap = 4'h0;
                else if (instr.word[7:0] == `ABX_SRC_ACC)
                    next_ap = step_ap;
            end
            default:
                fault = stk_fault
                    || (instr.word[15:8] == 8'h8a && instr.word[7:0] == `ABX_SRC_AIDX);
        endcase
        if (fault)
        begin
            acc_we     = 1'b0;
            sz_from_ap = 1'b0;
            next_ap    = accumulator_pointer;
            next_apc   = apc_bits;
            next_flags = flags;
            next_ip    = instruction_pointer + 16'h0001;
            next_sp    = stack_pointer;
            push_en    = 1'b0;
            lc_we      = 1'b0;
            bit_ext    = 1'b0;
        end
        next_active = acc_bank[next_ap];
        if (sz_from_ap)
        begin
            next_flags.s = next_active[W-1];
            next_flags.z = (next_active == '0);
        end
    end

    // Visible accumulator follows writes and pointer moves
    assign pre_acc = preload.valid && !preload.to_lc;
    always_comb
    begin
        next_acc_value = exec ? next_active : active;
        if (pre_acc && preload.idx == (exec ? next_ap : accumulator_pointer))
            next_acc_value = W'(preload.data);
        if (exec && acc_we && next_ap == accumulator_pointer)
            next_acc_value = alu_result;
    end

    // Accumulator bank
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                acc_bank[i] <= '0;
            acc_value <= '0;
        end
        else
        begin
            acc_value <= next_acc_value;
            if (pre_acc)
                acc_bank[preload.idx] <= W'(preload.data);
            if (exec && acc_we)
                acc_bank[accumulator_pointer] <= alu_result;
        end
    end

    // Pointer and its control
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            accumulator_pointer <= `ABX_AP_RST;
            apc_bits            <= `ABX_APC_RST;
        end
        else if (exec)
        begin
            accumulator_pointer <= next_ap;
            apc_bits            <= next_apc;
        end
    end

    assign pointer_control_register = {4'h0, apc_bits};

    // Status flags
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            flags <= '0;
        else if (exec)
            flags <= next_flags;
    end

    // Instruction pointer
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            instruction_pointer <= `ABX_IP_RST;
        else if (exec)
            instruction_pointer <= next_ip;
    end

    // Stack storage
    always_ff @(posedge sys_clk)
    begin
        if (exec && push_en)
            stack_mem[next_sp] <= instruction_pointer + 16'h0001;
    end

    // Stack pointer and top
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            stack_pointer <= '1;
            stack_top     <= '0;
        end
        else if (exec && push_en)
        begin
            stack_pointer <= next_sp;
            stack_top     <= instruction_pointer + 16'h0001;
        end
        else
            stack_top <= stack_mem[stack_pointer];
    end

    // Loop counters
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            loop_counter <= {2{`ABX_LC_RST}};
        else if (exec && lc_we)
            loop_counter[instr.word[12]] <= next_lc;
        else if (preload.valid && preload.to_lc)
            loop_counter[preload.idx[0]] <= preload.data;
    end

    // Prefix byte lives for one executed word
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pfx_byte <= 8'h00;
            pfx_live <= 1'b0;
        end
        else if (pfx.valid)
        begin
            pfx_byte <= pfx.value;
            pfx_live <= 1'b1;
        end
        else if (exec)
            pfx_live <= 1'b0;
    end

    // Outside bit writes and fault pulse
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            bit_write     <= '0;
            illegal_instr <= 1'b0;
        end
        else
        begin
            bit_write.valid     <= exec && bit_ext;
            bit_write.dst       <= instr.word[14:8];
            bit_write.bit_index <= instr.word[6:4];
            bit_write.value     <= instr.word[7];
            illegal_instr       <= exec && fault;
        end
    end
endmodule : abx_exec_core

// [abx_exec_core_tb_top.sv]
// Self-checking bench for the execution block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module abx_exec_core_tb_top;
    import abx_pkg::*;
    logic               sys_clk = 1'b0;
    logic               reset = 1'b1;
    abx_instr_type      instr = '0;
    abx_pfx_type        pfx = '0;
    abx_load_type       preload = '0;
    logic [15:0]        acc_value, instruction_pointer, stack_top, rom_word;
    abx_flags_type      flags;
    logic [3:0]         stack_pointer, accumulator_pointer;
    logic [7:0]         pointer_control_register;
    logic [1:0][15:0]   loop_counter;
    logic               illegal_instr;
    abx_bitwr_type      bit_write;
    logic [2:0]         rom_addr = '0;
    int                 err_total = 0;
    int                 cmp_count = 0;
    int                 cycles = 0;
    abx_exec_core abx_exec_core_i (.sys_clk, .reset, .instr, .pfx, .preload, .acc_value,
        .flags, .instruction_pointer, .stack_pointer, .stack_top, .accumulator_pointer,
        .pointer_control_register, .loop_counter, .bit_write, .illegal_instr);
    abx_prog_rom abx_prog_rom_i (.addr(rom_addr), .word(rom_word));
    always #5 sys_clk = ~sys_clk;
    task automatic final_report;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic run(input logic [15:0] w);
        @(negedge sys_clk);
        instr <= '{1'b1, w, 16'h0000, 1'b1};
        pfx <= '0;
        preload <= '0;
        @(posedge sys_clk);
    endtask : run
    task automatic idle;
        @(negedge sys_clk);
        instr.valid <= 1'b0;
        pfx <= '0;
        preload <= '0;
    endtask : idle
    task automatic load(input logic lc, input logic [3:0] idx, input logic [15:0] d);
        @(negedge sys_clk);
        preload <= '{1'b1, lc, idx, d};
        instr.valid <= 1'b0;
        @(posedge sys_clk);
    endtask : load
    task automatic prefix(input logic [7:0] v);
        @(negedge sys_clk);
        pfx <= '{1'b1, v};
        preload <= '0;
        @(posedge sys_clk);
    endtask : prefix
    task automatic acase(input logic [15:0] a, b, w, e, input logic [4:0] fl, input logic [7:0] pv);
        load(1'b0, 4'h0, a);
        load(1'b0, 4'h3, b);
        if (pv != 8'h00)
            prefix(pv);
        run(w);
        idle();
        `CHK("acc_value", e, acc_value)
        `CHK("flags", fl, flags)
    endtask : acase
    task automatic t_alu;
        acase(16'h2345, 16'hff0f, 16'hca39, 16'h2254, 5'b10000, 8'h00);
        acase(16'h2345, 16'hdcba, 16'hea39, 16'h0000, 5'b10010, 8'h00);
        acase(16'h2345, 16'h0000, 16'h4ac0, 16'h2405, 5'b00000, 8'h00);
        acase(16'h2345, 16'hc000, 16'hca39, 16'he345, 5'b00100, 8'h00);
        acase(16'h2345, 16'h6789, 16'hca39, 16'h8ace, 5'b00101, 8'h00);
        acase(16'h2345, 16'h0f0f, 16'h9a39, 16'h0305, 5'b00001, 8'h00);
        acase(16'h2345, 16'h0000, 16'h1a33, 16'h2201, 5'b00001, 8'h22);
        acase(16'h0990, 16'h0000, 16'h8a1a, 16'hf66f, 5'b00101, 8'h00);
        acase(16'hffff, 16'h0000, 16'h8a1a, 16'h0000, 5'b00011, 8'h00);
        acase(16'h0145, 16'h0000, 16'h7845, 16'h0145, 5'b00011, 8'h00);
        acase(16'h0145, 16'h0000, 16'h7845, 16'h0145, 5'b01011, 8'h01);
        acase(16'h0145, 16'h0000, 16'hda2a, 16'h0145, 5'b11011, 8'h00);
        acase(16'h2345, 16'h0000, 16'h9a1a, 16'h2345, 5'b01011, 8'h00);
        acase(16'h2345, 16'h0000, 16'hda2a, 16'h2345, 5'b11011, 8'h00);
        acase(16'h2345, 16'h0000, 16'h9a8a, 16'h2345, 5'b11011, 8'h00);
        acase(16'h2345, 16'h0000, 16'h9aaa, 16'h2345, 5'b01011, 8'h00);
        $display("test alu done");
    endtask : t_alu
    task automatic t_refuse;
        load(1'b0, 4'h0, 16'h1234);
        for (int i = 0; i < 4; i++)
        begin
            rom_addr = 3'(i);
            idle();
            run(rom_word);
            idle();
            `CHK("illegal_instr", 1'b1, illegal_instr)
            `CHK("acc_value", 16'h1234, acc_value)
        end
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_branch;
        `CHK("stack_pointer", 4'hf, stack_pointer)
        prefix(8'h01);
        run(16'h3d20);
        idle();
        `CHK("instruction_pointer", 16'h0120, instruction_pointer)
        `CHK("stack_pointer", 4'h0, stack_pointer)
        run(16'h3d10);
        idle();
        `CHK("instruction_pointer", 16'h0130, instruction_pointer)
        `CHK("stack_top", 16'h0121, stack_top)
        run(16'h3df0);
        idle();
        `CHK("instruction_pointer", 16'h0120, instruction_pointer)
        load(1'b0, 4'h2, 16'h4567);
        run(16'hbd29);
        idle();
        `CHK("instruction_pointer", 16'h4567, instruction_pointer)
        load(1'b1, 4'h0, 16'h0002);
        run(16'h4dfc);
        idle();
        `CHK("instruction_pointer", 16'h4563, instruction_pointer)
        run(16'h4dfc);
        idle();
        `CHK("instruction_pointer", 16'h4564, instruction_pointer)
        `CHK("loop_counter", 16'h0000, loop_counter[0])
        $display("test branch done");
    endtask : t_branch
    task automatic t_pointer;
        load(1'b0, 4'h0, 16'h0009);
        run(16'h981a);
        idle();
        `CHK("pointer_control_register", 8'h09, pointer_control_register)
        run(16'h880a);
        idle();
        `CHK("accumulator_pointer", 4'h1, accumulator_pointer)
        load(1'b0, 4'h1, 16'h0089);
        run(16'h980a);
        idle();
        `CHK("accumulator_pointer", 4'h0, accumulator_pointer)
        run(16'hc887);
        idle();
        `CHK("flags.c", 1'b1, flags.c)
        run(16'h8097);
        idle();
        `CHK("bit_write", 12'h803, bit_write)
        $display("test pointer done");
    endtask : t_pointer
    initial
    begin
        repeat (8) @(negedge sys_clk);
        reset <= 1'b0;
        t_alu();
        t_refuse();
        t_branch();
        t_pointer();
        final_report();
    end
endmodule : abx_exec_core_tb_top

// [abx_pkg.sv]
// Types shared by the execution block
package abx_pkg;
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
        logic [15:0] ext_data;
        logic        ext_wide;
    } abx_instr_type;
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } abx_pfx_type;
    typedef struct packed {
        logic        valid;
        logic        to_lc;
        logic [3:0]  idx;
        logic [15:0] data;
    } abx_load_type;
    typedef struct packed {
        logic c;
        logic e;
        logic s;
        logic z;
        logic ov;
    } abx_flags_type;
    typedef struct packed {
        logic       valid;
        logic [6:0] dst;
        logic [2:0] bit_index;
        logic       value;
    } abx_bitwr_type;
    typedef enum logic [3:0] {
        CL_NONE     = 4'h0,
        CL_ADD      = 4'h1,
        CL_ADD_WITH_CARRY     = 4'h2,
        CL_AND      = 4'h3,
        CL_BITAND   = 4'h4,
        CL_CPL      = 4'h5,
        CL_CPLC     = 4'h6,
        CL_CALL     = 4'h7,
        CL_CMP      = 4'h8,
        CL_LOOP_DECREMENT_BRANCH     = 4'h9,
        CL_BITSET   = 4'ha,
        CL_MOVE_AP  = 4'hb,
        CL_MOVE_APC = 4'hc
    } abx_class_type;
    typedef enum logic [1:0] {
        ALU_ADD = 2'b00,
        ALU_AND = 2'b01,
        ALU_CPL = 2'b10
    } abx_alu_op_type;
endpackage : abx_pkg

// [abx_prog_rom.sv]
// Program memory model holding refused words
`timescale 1ns/1ps
module abx_prog_rom
(
    // Word address
    input  wire logic [2:0] addr,
    // Word read out
    output logic [15:0]     word
);
    always_comb
    begin
        case (addr)
            3'h0:    word = 16'hca0a;
            3'h1:    word = 16'hca1a;
            3'h2:    word = 16'h8d0d;
            3'h3:    word = 16'h8617;
            default: word = 16'hda3a;
        endcase
    end
endmodule : abx_prog_rom

// [abx_ptr_step.sv]
// Automatic accumulator pointer step with modulo window
`timescale 1ns/1ps
`include "abx_defines.svh"
module abx_ptr_step
(
    // Current pointer and its control bits
    input  wire logic [3:0] ap,
    input  wire logic [3:0] ctrl,
    // Stepped pointer
    output logic [3:0]      step_ap,
    output logic            active
);
    logic [3:0] mask;
    logic [3:0] moved;
    always_comb
    begin
        case (ctrl[3:2])
            2'b01:   mask = 4'h1;
            2'b10:   mask = 4'h3;
            2'b11:   mask = 4'h7;
            default: mask = 4'hf;
        endcase
        active = (ctrl[1:0] == `ABX_MODE_INC) || (ctrl[1:0] == `ABX_MODE_DEC);
        moved  = (ctrl[1:0] == `ABX_MODE_INC) ? ap + 4'h1 : ap - 4'h1;
        step_ap = active ? ((ap & ~mask) | (moved & mask)) : ap;
    end
endmodule : abx_ptr_step
